//--- rtl/qpd_defs.vh
// constants for the quad pot serial command decoder
`ifndef QPD_DEFS_VH
`define QPD_DEFS_VH
// address byte type field, arbitrary neutral value
`define QPD_TYPE_ID        4'h0a
// instruction opcodes (upper nibble)
`define QPD_OP_RD_WIPER    4'h9
`define QPD_OP_WR_WIPER    4'ha
`define QPD_OP_RD_PRESET   4'hb
`define QPD_OP_WR_PRESET   4'hc
`define QPD_OP_PRE2WIP     4'hd
`define QPD_OP_WIP2PRE     4'he
`define QPD_OP_STEP        4'h2
// field positions inside the instruction byte
`define QPD_OP_MSB         7
`define QPD_OP_LSB         4
`define QPD_PRE_MSB        3
`define QPD_PRE_LSB        2
`define QPD_POT_MSB        1
`define QPD_POT_LSB        0
// reset values and wiper step limits
`define QPD_PRESET_RST     8'h80
`define QPD_WIPER_MAX      8'hff
`define QPD_WIPER_MIN      8'h00
// nonvolatile write time and clock rate
`define QPD_NV_WRITE_MS    10
`define QPD_CLK_KHZ        125000
`define QPD_NV_CYCLES      (`QPD_NV_WRITE_MS * `QPD_CLK_KHZ)
`endif

//--- rtl/qpd_sync.v
// two flip-flop synchroniser with edge outputs
`timescale 1ns/1ps
module qpd_sync (
   input  wire clk_i,
   input  wire sys_rst_i,
   input  wire en_i,
   input  wire d_i,
   output reg  q_o,
   output wire rise_o,
   output wire fall_o
);
   reg meta_q;
   reg sync_q;
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         q_o    <= 1'b1;
      end else if (en_i) begin
         meta_q <= d_i;
         sync_q <= meta_q;
         q_o    <= sync_q;
      end
   end
   assign rise_o = sync_q & ~q_o;
   assign fall_o = ~sync_q & q_o;
endmodule

//--- rtl/qpd_top.v
// quad pot two-wire command decoder, device side
`timescale 1ns/1ps
`include "qpd_defs.vh"
module qpd_top #(
   parameter NV_CYCLES = `QPD_NV_CYCLES
) (
   input  wire        clk_i,
   input  wire        sys_rst_i,
   input  wire        clk_en_i,
   input  wire        scl_i,
   input  wire        sda_i,
   input  wire [3:0]  device_select_bits_i,
   output reg         sda_o,
   output reg         sda_oe_o,
   output reg  [31:0] wiper_position_o,
   output reg         nv_busy_o
);
   //*****************************************
   // state codes
   //*****************************************
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_INST = 3'd2;
   localparam ST_WDAT = 3'd3;
   localparam ST_RDAT = 3'd4;
   localparam ST_STEP = 3'd5;
   localparam ST_WAIT = 3'd6;

   //*****************************************
   // pin synchronisers
   //*****************************************
   wire scl_s, scl_rise, scl_fall;
   wire sda_s, sda_rise, sda_fall;
   qpd_sync u_scl (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .en_i      (clk_en_i),
      .d_i       (scl_i),
      .q_o       (scl_s),
      .rise_o    (scl_rise),
      .fall_o    (scl_fall)
   );
   qpd_sync u_sda (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .en_i      (clk_en_i),
      .d_i       (sda_i),
      .q_o       (sda_s),
      .rise_o    (sda_rise),
      .fall_o    (sda_fall)
   );
   wire start_c = scl_s & sda_fall;
   wire stop_c  = scl_s & sda_rise;

   //*****************************************
   // storage
   //*****************************************
   reg [7:0]  preset_q [0:15];
   reg [7:0]  wiper_q  [0:3];
   reg [2:0]  state_q;
   reg [3:0]  bit_q;
   reg [7:0]  shift_q;
   reg [7:0]  inst_q;
   reg        ack_ph_q;
   reg        step_arm_q;
   reg        step_up_q;
   reg        pend_nv_q;
   reg        pend_xfr_q;
   reg [7:0]  nv_data_q;
   reg [31:0] nv_cnt_q;
   reg [3:0]  dev_sel_q;
   reg        init_q;

   function [3:0] pidx;
      input [7:0] ins;
      pidx = {ins[`QPD_POT_MSB:`QPD_POT_LSB],
              ins[`QPD_PRE_MSB:`QPD_PRE_LSB]};
   endfunction

   wire [3:0] op_c  = shift_q[`QPD_OP_MSB:`QPD_OP_LSB];
   wire [1:0] pot_c = inst_q[`QPD_POT_MSB:`QPD_POT_LSB];
   wire [3:0] pi_c  = pidx(inst_q);
   wire [3:0] iop_c = inst_q[`QPD_OP_MSB:`QPD_OP_LSB];
   wire       busy_c = (nv_cnt_q != 32'h0000_0000);

   integer k;
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (k = 0; k < 16; k = k + 1)
            preset_q[k] <= `QPD_PRESET_RST;
         for (k = 0; k < 4; k = k + 1)
            wiper_q[k] <= `QPD_WIPER_MIN;
         state_q    <= ST_IDLE;
         bit_q      <= 4'h0;
         shift_q    <= 8'h00;
         inst_q     <= 8'h00;
         ack_ph_q   <= 1'b0;
         step_arm_q <= 1'b0;
         step_up_q  <= 1'b0;
         pend_nv_q  <= 1'b0;
         pend_xfr_q <= 1'b0;
         nv_data_q  <= 8'h00;
         nv_cnt_q   <= 32'h0000_0000;
         dev_sel_q  <= 4'h0;
         init_q     <= 1'b1;
         sda_o      <= 1'b0;
         sda_oe_o   <= 1'b0;
         wiper_position_o <= 32'h0000_0000;
         nv_busy_o  <= 1'b0;
      end else if (clk_en_i) begin
         if (init_q) begin
            init_q    <= 1'b0;
            dev_sel_q <= device_select_bits_i;
            for (k = 0; k < 4; k = k + 1)
               wiper_q[k] <= preset_q[k*4];
         end
         if (busy_c) begin
            nv_cnt_q <= nv_cnt_q - 32'h0000_0001;
            if (nv_cnt_q == 32'h0000_0001)
               preset_q[pi_c] <= nv_data_q;
         end
         if (start_c) begin
            state_q  <= ST_ADDR;
            bit_q    <= 4'h0;
            ack_ph_q <= 1'b0;
            sda_oe_o <= 1'b0;
            step_arm_q <= 1'b0;
         end else if (stop_c) begin
            state_q  <= ST_IDLE;
            sda_oe_o <= 1'b0;
            step_arm_q <= 1'b0;
            if (pend_nv_q)
               nv_cnt_q <= NV_CYCLES;
            if (pend_xfr_q)
               wiper_q[pot_c] <= preset_q[pi_c];
            pend_nv_q  <= 1'b0;
            pend_xfr_q <= 1'b0;
         end else if (scl_rise && !ack_ph_q) begin
            case (state_q)
               ST_ADDR, ST_INST, ST_WDAT: begin
                  shift_q <= {shift_q[6:0], sda_s};
                  bit_q   <= bit_q + 4'h1;
               end
               ST_RDAT: bit_q <= bit_q + 4'h1;
               ST_STEP: begin
                  step_arm_q <= 1'b1;
                  step_up_q  <= sda_s;
               end
               default: ;
            endcase
         end else if (scl_fall) begin
            if (ack_ph_q) begin
               ack_ph_q <= 1'b0;
               sda_oe_o <= 1'b0;
               bit_q    <= 4'h0;
               if (state_q == ST_RDAT) begin
                  sda_oe_o <= 1'b1;
                  sda_o    <= shift_q[7];
                  shift_q  <= {shift_q[6:0], 1'b0};
               end
            end else if (state_q == ST_RDAT) begin
               if (bit_q == 4'h8) begin
                  // single byte: release for the controller ack and stop
                  ack_ph_q <= 1'b1;
                  sda_oe_o <= 1'b0;
                  state_q  <= ST_WAIT;
               end else begin
                  sda_o   <= shift_q[7];
                  shift_q <= {shift_q[6:0], 1'b0};
               end
            end else if (state_q == ST_STEP) begin
               // a high phase counts only once it ends without a stop
               step_arm_q <= 1'b0;
               if (step_arm_q && step_up_q) begin
                  if (wiper_q[pot_c] != `QPD_WIPER_MAX)
                     wiper_q[pot_c] <= wiper_q[pot_c] + 8'h01;
               end else if (step_arm_q) begin
                  if (wiper_q[pot_c] != `QPD_WIPER_MIN)
                     wiper_q[pot_c] <= wiper_q[pot_c] - 8'h01;
               end
            end else if (bit_q == 4'h8) begin
               ack_ph_q <= 1'b1;
               case (state_q)
                  ST_ADDR: begin
                     if (shift_q[7:4] == `QPD_TYPE_ID &&
                         shift_q[3:0] == dev_sel_q && !busy_c) begin
                        sda_oe_o <= 1'b1;
                        sda_o    <= 1'b0;
                        state_q  <= ST_INST;
                     end else
                        state_q <= ST_WAIT;
                  end
                  ST_INST: begin
                     inst_q   <= shift_q;
                     sda_oe_o <= 1'b1;
                     sda_o    <= 1'b0;
                     case (op_c)
                        `QPD_OP_RD_WIPER: begin
                           state_q <= ST_RDAT;
                           shift_q <= wiper_q[shift_q[1:0]];
                        end
                        `QPD_OP_RD_PRESET: begin
                           state_q <= ST_RDAT;
                           shift_q <= preset_q[pidx(shift_q)];
                        end
                        `QPD_OP_WR_WIPER,
                        `QPD_OP_WR_PRESET: state_q <= ST_WDAT;
                        `QPD_OP_PRE2WIP: begin
                           pend_xfr_q <= 1'b1;
                           state_q    <= ST_WAIT;
                        end
                        `QPD_OP_WIP2PRE: begin
                           pend_nv_q <= 1'b1;
                           nv_data_q <= wiper_q[shift_q[1:0]];
                           state_q   <= ST_WAIT;
                        end
                        `QPD_OP_STEP: state_q <= ST_STEP;
                        default: begin
                           sda_oe_o <= 1'b0;
                           state_q  <= ST_WAIT;
                        end
                     endcase
                  end
                  ST_WDAT: begin
                     sda_oe_o <= 1'b1;
                     sda_o    <= 1'b0;
                     state_q  <= ST_WAIT;
                     if (iop_c == `QPD_OP_WR_WIPER)
                        wiper_q[pot_c] <= shift_q;
                     else begin
                        pend_nv_q <= 1'b1;
                        nv_data_q <= shift_q;
                     end
                  end
                  default: ;
               endcase
            end
         end
         wiper_position_o <= {wiper_q[3], wiper_q[2],
                              wiper_q[1], wiper_q[0]};
         nv_busy_o <= busy_c;
      end
   end
endmodule

//--- tb/qpd_host.sv
// two-wire bus master model driving scl and sda
`timescale 1ns/1ps
module qpd_host (
   input  wire clk_i,
   input  wire sda_i,
   output reg  scl_o,
   output reg  sda_o
);
   // 125 ns bus clock, phases kept off the system clock edges
   localparam real T_HALF = 62.5;
   localparam real T_SET  = 20.0;
   initial scl_o = 1'b1;
   initial sda_o = 1'b1;
   task start;
      begin
         @(posedge clk_i);
         #1.25;
         sda_o = 1'b0;
         #(T_HALF);
         scl_o = 1'b0;
      end
   endtask
   // data moves only well inside the low phase
   task bitx(input logic b, output logic r);
      begin
         #(T_SET);
         sda_o = b;
         #(T_HALF - T_SET);
         scl_o = 1'b1;
         #(T_HALF);
         r = sda_i;
         scl_o = 1'b0;
      end
   endtask
   task stop;
      begin
         #(T_SET);
         sda_o = 1'b0;
         #(T_HALF - T_SET);
         scl_o = 1'b1;
         #(T_HALF);
         sda_o = 1'b1;
         #(T_HALF);
      end
   endtask
   task wbyte(input logic [7:0] d, output logic a);
      logic r;
      begin
         for (int i = 7; i >= 0; i--) bitx(d[i], r);
         bitx(1'b1, r);
         a = ~r;
      end
   endtask
   // master acknowledges the returned byte; the caller sends the stop
   task rbyte(output logic [7:0] d);
      logic r;
      begin
         for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
         bitx(1'b0, r);
      end
   endtask
   // step mode: level held through the whole high phase
   task step(input logic up);
      logic r;
      bitx(up, r);
   endtask
endmodule

//--- tb/qpd_top_monitor.sv
// assertion checker for the quad pot command decoder
`timescale 1ns/1ps
`include "qpd_defs.vh"
module qpd_top_monitor #(
   parameter NV_CYCLES = 50
) (
   input wire        clk_i,
   input wire        sys_rst_i,
   input wire        clk_en_i,
   input wire        scl_i,
   input wire        sda_i,
   input wire [3:0]  device_select_bits_i,
   input wire        sda_o,
   input wire        sda_oe_o,
   input wire [31:0] wiper_position_o,
   input wire        nv_busy_o
);
   int busy_cnt_q;
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         busy_cnt_q <= 0;
      else if (clk_en_i)
         busy_cnt_q <= nv_busy_o ? busy_cnt_q + 1 : 0;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data driver moved while scl high");
   a_ack_holds: assert property ($rose(sda_oe_o) |=> sda_oe_o[*4])
      else $error("driven bit released too early");
   a_busy_nack: assert property (nv_busy_o |-> !sda_oe_o)
      else $error("bus driven during nonvolatile write");
   a_busy_after_stop: assert property ($rose(nv_busy_o) |-> scl_i)
      else $error("nonvolatile write began outside a stop");
   a_busy_min_len: assert property ($fell(nv_busy_o) |->
      busy_cnt_q >= NV_CYCLES - 2)
      else $error("nonvolatile write too short");
   a_busy_max_len: assert property (busy_cnt_q <= NV_CYCLES + 2)
      else $error("nonvolatile write too long");
   a_wiper_init: assert property ($fell(sys_rst_i) |->
      ##[0:3] wiper_position_o == {4{`QPD_PRESET_RST}})
      else $error("wipers not loaded from preset zero");
   a_busy_wiper_hold: assert property (nv_busy_o && $past(nv_busy_o)
      |-> $stable(wiper_position_o))
      else $error("wiper moved during nonvolatile write");
   a_freeze_hold: assert property (!clk_en_i |=>
      $stable(wiper_position_o) && $stable(nv_busy_o))
      else $error("state moved while clock enable low");
   c_busy: cover property ($rose(nv_busy_o));
   c_freeze: cover property (!clk_en_i);
   c_drive: cover property ($rose(sda_oe_o));
   c_wiper: cover property ($changed(wiper_position_o));
endmodule
bind qpd_top qpd_top_monitor #(.NV_CYCLES(NV_CYCLES)) u_qpd_top_monitor (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
   .scl_i(scl_i), .sda_i(sda_i), .device_select_bits_i(device_select_bits_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wiper_position_o(wiper_position_o),
   .nv_busy_o(nv_busy_o));

//--- tb/tb_top.sv
// testbench for the quad pot command decoder
`timescale 1ns/1ps
`include "qpd_defs.vh"
module tb_top;
   localparam [3:0] SEL = 4'h6;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        clk_en = 1'b1;
   logic        sda_out, sda_oe, nv_busy, scl_w, host_sda, sda_w, a1, a2, a3;
   logic [31:0] wip;
   logic [7:0]  rd;
   int          fail_count = 0;
   int          n_checks = 0;
   always #4 clk_i = ~clk_i;
   assign sda_w = host_sda & ~(sda_oe & ~sda_out);
   qpd_host u_qpd_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w),
      .sda_o(host_sda));
   qpd_top #(.NV_CYCLES(400)) u_qpd_top (.clk_i(clk_i),
      .sys_rst_i(sys_rst_i), .clk_en_i(clk_en), .scl_i(scl_w), .sda_i(sda_w),
      .device_select_bits_i(SEL), .sda_o(sda_out), .sda_oe_o(sda_oe),
      .wiper_position_o(wip), .nv_busy_o(nv_busy));
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      begin
         n_checks++;
         if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task frame(input logic [3:0] s, input logic [7:0] ins);
      begin
         u_qpd_host.start;
         u_qpd_host.wbyte({`QPD_TYPE_ID, s}, a1);
         u_qpd_host.wbyte(ins, a2);
      end
   endtask
   task wr(input logic [7:0] ins, input logic [7:0] d);
      begin
         frame(SEL, ins);
         u_qpd_host.wbyte(d, a3);
         u_qpd_host.stop;
         chk("acks", 3'b111, {a1, a2, a3});
      end
   endtask
   task rdc(input logic [7:0] ins);
      begin
         frame(SEL, ins);
         u_qpd_host.rbyte(rd);
         u_qpd_host.stop;
      end
   endtask
   task nvwait;
      int i;
      begin
         for (i = 0; i < 1000 && nv_busy !== 1'b0; i++) @(negedge clk_i);
         chk("nv busy", 1'b0, nv_busy);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      fail_count++;
      $display("watchdog expired");
      summarize;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk("wiper init", 32'h8080_8080, wip);
      $display("test reset done");
      wr(8'had, 8'h5a);
      chk("wiper write", 8'h5a, wip[15:8]);
      rdc(8'h91);
      chk("wiper read", 8'h5a, rd);
      frame(SEL ^ 4'h1, 8'h91);
      u_qpd_host.stop;
      chk("select nack", 1'b0, a1);
      $display("test wiper access done");
      frame(SEL, 8'h21);
      repeat (3) u_qpd_host.step(1'b1);
      u_qpd_host.step(1'b0);
      u_qpd_host.stop;
      chk("steps", 8'h5c, wip[15:8]);
      wr(8'ha2, 8'hff);
      wr(8'ha3, 8'h00);
      frame(SEL, 8'h22);
      u_qpd_host.step(1'b1);
      u_qpd_host.stop;
      frame(SEL, 8'h23);
      u_qpd_host.step(1'b0);
      u_qpd_host.stop;
      chk("clamp", 16'h00ff, wip[31:16]);
      $display("test step done");
      wr(8'hc8, 8'h3c);
      frame(SEL, 8'h91);
      u_qpd_host.stop;
      chk("poll nack", 1'b0, a1);
      nvwait;
      rdc(8'hb8);
      chk("preset read", 8'h3c, rd);
      rdc(8'hb0);
      chk("preset zero", `QPD_PRESET_RST, rd);
      $display("test preset done");
      frame(SEL, 8'hd8);
      u_qpd_host.stop;
      chk("copy to wiper", 8'h3c, wip[7:0]);
      frame(SEL, 8'hed);
      u_qpd_host.stop;
      nvwait;
      rdc(8'hbd);
      chk("copy to preset", 8'h5c, rd);
      $display("test copy done");
      @(posedge clk_i);
      clk_en <= 1'b0;
      frame(SEL, 8'ha0);
      u_qpd_host.wbyte(8'h11, a3);
      u_qpd_host.stop;
      chk("freeze ack", 1'b0, a1);
      chk("freeze wiper", 8'h3c, wip[7:0]);
      @(posedge clk_i);
      clk_en <= 1'b1;
      repeat (8) @(posedge clk_i);
      wr(8'ha0, 8'h11);
      chk("thaw wiper", 8'h11, wip[7:0]);
      $display("test freeze done");
      summarize;
   end
endmodule
